// ===== design/mode_reg_pkg.sv
// Constants, types and decode functions shared by both link ends.
// Assumes a single pclk domain at 25 MHz.
// How it works
// - Sixteen-beat sequential bursts count up modulo sixteen
// - Controller refuses unsupported order and length pairs
// - Column bit zero is always taken as zero
// - Start offset from low two, three or four bits
// - No-wrap four-beat bursts never cross page edges
// - Controller refuses the prohibited no-wrap start columns
// - Latency register decodes read and write latency
// - Drive register holds the drive strength code
// - Temperature register reports the refresh rate code
// - Codes five and six mean quarter interval
// - Codes zero and seven flag temperature limits
// - Update flag sets when refresh code changes
// - Reading temperature register clears the update flag
// - Update flag is zero after reset
// - Refresh code bit two means above 85C
// - Controller reports derating and the 1.875ns margin, rounded up to one cycle, in its status
// - Maker code register returns an eight-bit code
// - Burst feature register selects length and order
package mode_reg_pkg;
    localparam logic [7:0] MR_BURST = 8'h01;
    localparam logic [7:0] MR_LAT = 8'h02;
    localparam logic [7:0] MR_DRV = 8'h03;
    localparam logic [7:0] MR_TEMP = 8'h04;
    localparam logic [7:0] MR_MAKER = 8'h05;
    localparam int UPDATE_FLAG_BIT = 7;
    localparam int ORDER_BIT = 3;
    localparam int WRAP_BIT = 4;
    localparam int COL_W = 11;
    localparam logic [2:0] BEATS_4 = 3'h2;
    localparam logic [2:0] BEATS_8 = 3'h3;
    localparam logic [2:0] BEATS_16 = 3'h4;
    localparam logic [7:0] BURST_RESET = 8'h02;
    localparam logic [3:0] LAT_RESET = 4'h1;
    localparam logic [3:0] DRV_RESET = 4'h2;
    localparam logic [2:0] REFRESH_RESET = 3'h3;
    localparam logic [2:0] RATE_LOW_LIMIT = 3'h0;
    localparam logic [2:0] RATE_DERATE = 3'h6;
    localparam logic [2:0] RATE_HIGH_LIMIT = 3'h7;
    localparam logic [11:0] CMD_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [11:0] BURST_OFF = 12'h008;
    localparam logic [11:0] IRQ_STAT_OFF = 12'h00c;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h010;
    localparam int IRQ_READ = 0;
    localparam int IRQ_BURST = 1;
    localparam int IRQ_REFUSED = 2;
    localparam int IRQ_TEMP = 3;
    localparam int DERATE_PS = 1875;
    localparam int CLK_PERIOD_PS = 40000;
    localparam logic [3:0] DERATE_CYCLES = 4'((DERATE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    typedef enum logic [1:0] {IDLE = 2'h0, WAIT_READ = 2'h1, WAIT_BURST = 2'h2} ctrl_state_t;

    function automatic logic lat_legal(input logic [3:0] c);
        lat_legal = (c >= 4'h1) && (c <= 4'h6);
    endfunction : lat_legal

    function automatic logic drv_legal(input logic [3:0] c);
        drv_legal = (c != 4'h0) && (c != 4'h5) && (c <= 4'h7);
    endfunction : drv_legal

    function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] bl);
        case (bl)
            BEATS_8: burst_mask = 11'h007;
            BEATS_16: burst_mask = 11'h00f;
            default: burst_mask = 11'h003;
        endcase
    endfunction : burst_mask
endpackage : mode_reg_pkg

// ===== design/mode_link_if.sv
// Command/address link between the memory controller and the device.
// Assumes both ends run on pclk.
`timescale 1ns/10ps
`default_nettype none
interface mode_link_if;
    logic cmd_valid;
    logic cmd_write;
    logic [7:0] mode_register_index;
    logic [7:0] mode_register_payload;
    logic rd_valid;
    logic [7:0] rd_data;
    logic burst_req;
    logic [10:1] burst_col;
    logic beat_valid;
    logic beat_last;
    logic [10:0] beat_col;
    modport host (output cmd_valid, cmd_write, mode_register_index, mode_register_payload, burst_req, burst_col,
                  input rd_valid, rd_data, beat_valid, beat_last, beat_col);
    modport dev (input cmd_valid, cmd_write, mode_register_index, mode_register_payload, burst_req, burst_col,
                 output rd_valid, rd_data, beat_valid, beat_last, beat_col);
endinterface : mode_link_if
`default_nettype wire

// ===== design/mode_reg_device.sv
// Device end: mode registers, temperature status and burst column sequencer.
// Assumes the controller keeps to legal bursts and commands.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module mode_reg_device
    import mode_reg_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5a // Arbitrary value
)
(
    input wire logic pclk,
    input wire logic presetn,
    mode_link_if.dev link,
    input wire logic [2:0] sensor_rate_code,
    output logic [3:0] read_latency,
    output logic [3:0] write_latency,
    output logic [3:0] output_drive_strength,
    output logic derate_timing,
    output logic above_85c,
    output logic temp_limit_fault
);
    logic [7:0] burst_cfg_r;
    logic [3:0] lat_r;
    logic [3:0] drv_r;
    logic [2:0] rate_s1_r;
    logic [2:0] rate_s2_r;
    logic [2:0] rate_q_r;
    logic temperature_update_flag_r;
    logic rd_valid_r;
    logic [7:0] rd_data_r;
    logic active_r;
    logic [3:0] idx_r;
    logic [COL_W-1:0] start_r;
    logic [COL_W-1:0] mask_r;
    logic order_r;
    logic wrap_r;
    logic beat_valid_r;
    logic beat_last_r;
    logic [COL_W-1:0] beat_col_r;
    logic mrw;
    logic mrr;
    logic rate_changed;
    logic [COL_W-1:0] beat_nxt;
    logic [COL_W-1:0] step;

    assign mrw = link.cmd_valid && link.cmd_write;
    assign mrr = link.cmd_valid && !link.cmd_write;

    // Mode register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            burst_cfg_r <= BURST_RESET;
            lat_r <= LAT_RESET;
            drv_r <= DRV_RESET;
        end
        else if (mrw)
        begin
            if (link.mode_register_index == MR_BURST)
            begin
                burst_cfg_r <= link.mode_register_payload;
            end
            if (link.mode_register_index == MR_LAT && lat_legal(link.mode_register_payload[3:0]))
            begin
                lat_r <= link.mode_register_payload[3:0];
            end
            if (link.mode_register_index == MR_DRV && drv_legal(link.mode_register_payload[3:0]))
            begin
                drv_r <= link.mode_register_payload[3:0];
            end
        end
    end

    // Sensor code synchroniser
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rate_s1_r <= REFRESH_RESET;
            rate_s2_r <= REFRESH_RESET;
            rate_q_r <= REFRESH_RESET;
        end
        else
        begin
            rate_s1_r <= sensor_rate_code;
            rate_s2_r <= rate_s1_r;
            rate_q_r <= rate_s2_r;
        end
    end

    assign rate_changed = rate_s2_r != rate_q_r;

    // Update flag; a change in the read cycle keeps it set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            temperature_update_flag_r <= 1'b0;
        end
        else if (rate_changed)
        begin
            temperature_update_flag_r <= 1'b1;
        end
        else if (mrr && link.mode_register_index == MR_TEMP)
        begin
            temperature_update_flag_r <= 1'b0;
        end
    end

    // Mode register reads
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h00;
        end
        else
        begin
            rd_valid_r <= mrr;
            if (mrr)
            begin
                case (link.mode_register_index)
                    MR_LAT: rd_data_r <= {4'h0, lat_r};
                    MR_DRV: rd_data_r <= {4'h0, drv_r};
                    MR_TEMP: rd_data_r <= {temperature_update_flag_r, 4'h0, rate_q_r};
                    MR_MAKER: rd_data_r <= MAKER_ID;
                    default: rd_data_r <= 8'h00;
                endcase
            end
        end
    end

    // Settings and temperature outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            read_latency <= 4'h0;
            write_latency <= 4'h0;
            output_drive_strength <= 4'h0;
            derate_timing <= 1'b0;
            above_85c <= 1'b0;
            temp_limit_fault <= 1'b0;
        end
        else
        begin
            read_latency <= lat_r + 4'h2;
            case (lat_r)
                4'h1: write_latency <= 4'h1;
                4'h2, 4'h3: write_latency <= 4'h2;
                4'h4: write_latency <= 4'h3;
                default: write_latency <= 4'h4;
            endcase
            output_drive_strength <= drv_r;
            derate_timing <= rate_q_r == RATE_DERATE;
            above_85c <= rate_q_r[2];
            temp_limit_fault <= rate_q_r == RATE_LOW_LIMIT || rate_q_r == RATE_HIGH_LIMIT;
        end
    end

    // Beat column: wrap inside the burst window, or walk on for no-wrap
    assign step = start_r + {7'h00, idx_r};
    always_comb
    begin
        if (wrap_r)
        begin
            beat_nxt = start_r + {7'h00, idx_r};
        end
        else if (order_r)
        begin
            beat_nxt = (start_r & ~mask_r) | ((start_r ^ {7'h00, idx_r}) & mask_r);
        end
        else
        begin
            beat_nxt = (start_r & ~mask_r) | (step & mask_r);
        end
    end

    // Burst sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            active_r <= 1'b0;
            idx_r <= 4'h0;
            start_r <= '0;
            mask_r <= '0;
            order_r <= 1'b0;
            wrap_r <= 1'b0;
            beat_valid_r <= 1'b0;
            beat_last_r <= 1'b0;
            beat_col_r <= '0;
        end
        else
        begin
            beat_valid_r <= active_r;
            beat_last_r <= active_r && idx_r == mask_r[3:0];
            if (active_r)
            begin
                beat_col_r <= beat_nxt;
                idx_r <= idx_r + 4'h1;
                if (idx_r == mask_r[3:0])
                begin
                    active_r <= 1'b0;
                end
            end
            else if (link.burst_req)
            begin
                active_r <= 1'b1;
                idx_r <= 4'h0;
                start_r <= {link.burst_col, 1'b0};
                mask_r <= burst_mask(burst_cfg_r[2:0]);
                order_r <= burst_cfg_r[ORDER_BIT];
                wrap_r <= burst_cfg_r[WRAP_BIT];
            end
        end
    end

    assign link.rd_valid = rd_valid_r;
    assign link.rd_data = rd_data_r;
    assign link.beat_valid = beat_valid_r;
    assign link.beat_last = beat_last_r;
    assign link.beat_col = beat_col_r;
endmodule : mode_reg_device
`default_nettype wire

// ===== design/mode_reg_controller.sv
// Controller end: APB registers issue mode commands and bursts on the link.
// Assumes an APB master on pclk and the device on the link.
`timescale 1ns/10ps
`default_nettype none
module mode_reg_controller
    import mode_reg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic irq,
    mode_link_if.host link
);
    ctrl_state_t state_r;
    logic [7:0] burst_cfg_r;
    logic [7:0] last_rd_r;
    logic derate_r;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_mask_r;
    logic [3:0] ev;
    logic cmd_valid_r;
    logic cmd_write_r;
    logic [7:0] idx_r;
    logic [7:0] pay_r;
    logic burst_req_r;
    logic [10:1] burst_col_r;
    logic access;
    logic wr_fire;
    logic mapped;
    logic bad_cfg;
    logic bad_col;
    logic [10:0] col;

    assign access = psel && penable && !pready;
    assign wr_fire = psel && penable && pready && pwrite;
    assign mapped = paddr == CMD_OFF || paddr == STAT_OFF || paddr == BURST_OFF
                    || paddr == IRQ_STAT_OFF || paddr == IRQ_MASK_OFF;
    assign col = {pwdata[10:1], 1'b0};
    assign bad_cfg = (burst_cfg_r[2:0] == BEATS_16 && burst_cfg_r[ORDER_BIT])
                     || (burst_cfg_r[WRAP_BIT] && burst_cfg_r[2:0] != BEATS_4);
    assign bad_col = burst_cfg_r[WRAP_BIT] && (col == 11'h7fe || col == 11'h000
                     || col == 11'h3fe || col == 11'h400);

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access;
            pslverr <= access && !mapped;
            if (access && !pwrite)
            begin
                case (paddr)
                    STAT_OFF: prdata <= {16'h0000, DERATE_CYCLES, 2'h0, derate_r, state_r != IDLE, last_rd_r};
                    IRQ_STAT_OFF: prdata <= {28'h0000000, irq_stat_r};
                    IRQ_MASK_OFF: prdata <= {28'h0000000, irq_mask_r};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Command and burst launch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= IDLE;
            burst_cfg_r <= BURST_RESET;
            last_rd_r <= 8'h00;
            derate_r <= 1'b0;
            cmd_valid_r <= 1'b0;
            cmd_write_r <= 1'b0;
            idx_r <= 8'h00;
            pay_r <= 8'h00;
            burst_req_r <= 1'b0;
            burst_col_r <= '0;
            ev <= 4'h0;
        end
        else
        begin
            cmd_valid_r <= 1'b0;
            burst_req_r <= 1'b0;
            ev <= 4'h0;
            unique case (state_r)
                IDLE:
                begin
                    if (wr_fire && paddr == CMD_OFF)
                    begin
                        cmd_valid_r <= 1'b1;
                        cmd_write_r <= pwdata[16];
                        idx_r <= pwdata[7:0];
                        pay_r <= pwdata[15:8];
                        if (pwdata[16] && pwdata[7:0] == MR_BURST)
                        begin
                            burst_cfg_r <= pwdata[15:8];
                        end
                        if (!pwdata[16])
                        begin
                            state_r <= WAIT_READ;
                        end
                    end
                    else if (wr_fire && paddr == BURST_OFF)
                    begin
                        if (bad_cfg || bad_col)
                        begin
                            ev[IRQ_REFUSED] <= 1'b1;
                        end
                        else
                        begin
                            burst_req_r <= 1'b1;
                            burst_col_r <= pwdata[10:1];
                            state_r <= WAIT_BURST;
                        end
                    end
                end
                WAIT_READ:
                begin
                    if (link.rd_valid)
                    begin
                        last_rd_r <= link.rd_data;
                        ev[IRQ_READ] <= 1'b1;
                        if (idx_r == MR_TEMP)
                        begin
                            derate_r <= link.rd_data[2:0] == RATE_DERATE;
                            ev[IRQ_TEMP] <= link.rd_data[UPDATE_FLAG_BIT];
                        end
                        state_r <= IDLE;
                    end
                end
                WAIT_BURST:
                begin
                    if (link.beat_last)
                    begin
                        ev[IRQ_BURST] <= 1'b1;
                        state_r <= IDLE;
                    end
                end
            endcase
            if (wr_fire && state_r != IDLE && (paddr == CMD_OFF || paddr == BURST_OFF))
            begin
                ev[IRQ_REFUSED] <= 1'b1;
            end
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
            irq <= 1'b0;
        end
        else
        begin
            irq_stat_r <= ev | (irq_stat_r & ~((wr_fire && paddr == IRQ_STAT_OFF) ? pwdata[3:0] : 4'h0));
            if (wr_fire && paddr == IRQ_MASK_OFF)
            begin
                irq_mask_r <= pwdata[3:0];
            end
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign link.cmd_valid = cmd_valid_r;
    assign link.cmd_write = cmd_write_r;
    assign link.mode_register_index = idx_r;
    assign link.mode_register_payload = pay_r;
    assign link.burst_req = burst_req_r;
    assign link.burst_col = burst_col_r;
endmodule : mode_reg_controller
`default_nettype wire

// ===== dv/mode_link_sva.sv
// Checker for the mode link between controller and device.
// Assumes it sits beside the link interface, on pclk and presetn.
`timescale 1ns/10ps
`default_nettype none
module mode_link_sva
    import mode_reg_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5a
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] mode_register_index,
    input wire logic [7:0] mode_register_payload,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic burst_req,
    input wire logic [10:1] burst_col,
    input wire logic beat_valid,
    input wire logic beat_last,
    input wire logic [10:0] beat_col
);
    logic [7:0] cfg_r;
    logic [4:0] cnt_r;
    logic [10:0] prev_r;
    logic [4:0] len;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_r <= BURST_RESET;
        else if (cmd_valid && cmd_write && mode_register_index == MR_BURST)
            cfg_r <= mode_register_payload;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_r <= 5'h0;
        else if (beat_valid)
            cnt_r <= beat_last ? 5'h0 : cnt_r + 5'h1;
    end
    always_ff @(posedge pclk)
    begin
        prev_r <= beat_col;
    end
    assign len = (cfg_r[2:0] == BEATS_16) ? 5'h10 : (cfg_r[2:0] == BEATS_8) ? 5'h08 : 5'h04;
    sequence s_rd(logic [7:0] idx);
        cmd_valid && !cmd_write && mode_register_index == idx;
    endsequence
    sequence s_step16;
        beat_valid && !beat_last && cfg_r[4:0] == {2'b00, BEATS_16};
    endsequence
    property p_maker;
        s_rd(MR_MAKER) |=> rd_valid && rd_data == MAKER_ID;
    endproperty
    property p_temp;
        s_rd(MR_TEMP) |=> rd_valid && rd_data[6:3] == 4'h0;
    endproperty
    property p_lat;
        s_rd(MR_LAT) |=> rd_valid && rd_data[7:4] == 4'h0 && rd_data[3:0] inside {[4'h1:4'h6]};
    endproperty
    property p_drv;
        s_rd(MR_DRV) |=> rd_valid && rd_data[7:4] == 4'h0 && rd_data[3:0] inside {[4'h1:4'h4], 4'h6, 4'h7};
    endproperty
    property p_even;
        beat_valid && !$past(beat_valid) |-> !beat_col[0];
    endproperty
    property p_first;
        burst_req |-> ##2 beat_valid && beat_col == {$past(burst_col, 2), 1'b0};
    endproperty
    property p_step;
        s_step16 |=> beat_valid && beat_col == {prev_r[10:4], prev_r[3:0] + 4'h1};
    endproperty
    property p_len;
        beat_valid && beat_last |-> cnt_r + 5'h1 == len;
    endproperty
    a_maker: assert property (p_maker) else $error("maker code wrong");
    a_temp: assert property (p_temp) else $error("temperature spare bits set");
    a_lat: assert property (p_lat) else $error("latency code bad");
    a_drv: assert property (p_drv) else $error("drive code bad");
    a_even: assert property (p_even) else $error("burst starts odd");
    a_first: assert property (p_first) else $error("first beat wrong");
    a_step: assert property (p_step) else $error("long burst step wrong");
    a_len: assert property (p_len) else $error("burst length wrong");
endmodule : mode_link_sva
`default_nettype wire

// ===== dv/tb_top.sv
// Testbench: APB master on the controller, device outputs and link watched.
// Assumes package, link interface, both ends and checker compile first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import mode_reg_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
    localparam logic [3:0] WLT [7] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4};
    localparam logic [2:0] TCODES [7] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h0, 3'h3};
    localparam logic [7:0] CFGS [6] = '{8'h22, 8'h23, 8'h2b, 8'h24, 8'h32, 8'h2a};
    localparam logic [7:0] RCFG [2] = '{8'h32, 8'h2c};
    localparam logic [10:0] RCOL [2] = '{11'h7fe, 11'h010};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] sensor = 3'h3;
    logic pready;
    logic pslverr;
    logic irq;
    logic derate;
    logic hot;
    logic fault;
    logic [31:0] prdata;
    logic [3:0] rlat;
    logic [3:0] wlat;
    logic [3:0] drv;
    logic [31:0] rdv;
    logic [32:0] rq_d [$];
    logic [32:0] rq_m [$];
    logic [11:0] cq [$];
    int err_count = 0;
    int tests_run = 0;
    mode_link_if link ();
    mode_reg_controller mode_reg_controller_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .irq(irq), .link(link));
    mode_reg_device #(.MAKER_ID(MAKER)) mode_reg_device_i (.pclk(pclk), .presetn(presetn), .link(link),
        .sensor_rate_code(sensor), .read_latency(rlat), .write_latency(wlat), .output_drive_strength(drv),
        .derate_timing(derate), .above_85c(hot), .temp_limit_fault(fault));
    mode_link_sva #(.MAKER_ID(MAKER)) mode_link_sva_i (.pclk(pclk), .presetn(presetn),
        .cmd_valid(link.cmd_valid), .cmd_write(link.cmd_write), .mode_register_index(link.mode_register_index),
        .mode_register_payload(link.mode_register_payload), .rd_valid(link.rd_valid), .rd_data(link.rd_data),
        .burst_req(link.burst_req), .burst_col(link.burst_col), .beat_valid(link.beat_valid),
        .beat_last(link.beat_last), .beat_col(link.beat_col));
    always #20 pclk = ~pclk;
    task automatic fail(input string s);
        err_count++;
        $display("ERROR %0t: %s", $time, s);
    endtask : fail
    task automatic end_sim;
        $display("tests %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic cmp_reg(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] m);
        if (m != 33'h0)
        begin
            tests_run++;
            if ((got & m) !== exp)
                fail("register read mismatch");
        end
    endtask : cmp_reg
    task automatic cmp_beat(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp)
            fail("beat column mismatch");
    endtask : cmp_beat
    task automatic cmp_out(input logic [3:0] got, input logic [3:0] exp, input string s);
        tests_run++;
        if (got !== exp)
            fail(s);
    endtask : cmp_out
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite && rq_d.size() > 0)
            cmp_reg({pslverr, prdata}, rq_d.pop_front(), rq_m.pop_front());
        if (link.beat_valid === 1'b1)
        begin
            if (cq.size() == 0)
                fail("unexpected beat");
            else
                cmp_beat({link.beat_last, link.beat_col}, cq.pop_front());
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e,
                       input logic [32:0] m);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
        begin
            rq_d.push_back(e & m);
            rq_m.push_back(m);
        end
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (n == 50)
        begin
            fail("pready timeout");
            end_sim();
        end
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_idle;
        int n;
        for (n = 0; n < 20; n++)
        begin
            apb(1'b0, STAT_OFF, 32'h0, 33'h0, 33'h0);
            if (rdv[8] === 1'b0)
                break;
        end
        if (n == 20)
        begin
            fail("busy timeout");
            end_sim();
        end
    endtask : wait_idle
    task automatic mr(input logic w, input logic [7:0] idx, input logic [7:0] pay);
        apb(1'b1, CMD_OFF, {15'h0, w, pay, idx}, 33'h0, 33'h0);
        wait_idle();
    endtask : mr
    task automatic rd_mr(input logic [7:0] idx, input logic [7:0] e);
        mr(1'b0, idx, 8'h00);
        apb(1'b0, STAT_OFF, 32'h0, {25'h0, e}, 33'h0ff);
    endtask : rd_mr
    initial
    begin
        int c, i, n;
        logic [3:0] last;
        logic [10:0] col;
        void'($urandom(32'h8e19));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        cmp_out(rlat, 4'h3, "reset read latency");
        cmp_out(wlat, 4'h1, "reset write latency");
        cmp_out(drv, 4'h2, "reset drive");
        rd_mr(MR_TEMP, 8'h03);
        $display("test reset done");
        last = 4'h1;
        for (c = 0; c < 8; c++)
        begin
            mr(1'b1, MR_LAT, {4'($urandom), 4'(c)});
            if (c >= 1 && c <= 6)
                last = 4'(c);
            cmp_out(rlat, last + 4'h2, "read latency");
            cmp_out(wlat, WLT[last], "write latency");
        end
        rd_mr(MR_LAT, {4'h0, last});
        last = 4'h2;
        for (c = 0; c < 16; c++)
        begin
            mr(1'b1, MR_DRV, {4'($urandom), 4'(c)});
            if (c inside {[1:4], 6, 7})
                last = 4'(c);
            cmp_out(drv, last, "drive strength");
        end
        rd_mr(MR_DRV, {4'h0, last});
        $display("test latency and drive done");
        apb(1'b1, IRQ_MASK_OFF, 32'hf7, 33'h0, 33'h0);
        apb(1'b1, IRQ_STAT_OFF, 32'hf, 33'h0, 33'h0);
        for (c = 0; c < 7; c++)
        begin
            sensor <= TCODES[c];
            repeat (5) @(posedge pclk);
            cmp_out({3'h0, derate}, {3'h0, TCODES[c] == 3'h6}, "derate");
            cmp_out({3'h0, hot}, {3'h0, TCODES[c][2]}, "above 85");
            cmp_out({3'h0, fault}, {3'h0, TCODES[c] inside {3'h0, 3'h7}}, "limit fault");
            rd_mr(MR_TEMP, {5'h10, TCODES[c]});
            rd_mr(MR_TEMP, {5'h00, TCODES[c]});
            apb(1'b0, STAT_OFF, 32'h0, {17'h0, DERATE_CYCLES, 2'h0, TCODES[c] == 3'h6, 9'h0}, 33'hf200);
        end
        cmp_out({3'h0, irq}, 4'h1, "irq raise");
        apb(1'b1, IRQ_MASK_OFF, 32'h0, 33'h0, 33'h0);
        repeat (2) @(posedge pclk);
        cmp_out({3'h0, irq}, 4'h0, "irq mask");
        apb(1'b1, IRQ_STAT_OFF, 32'hf, 33'h0, 33'h0);
        apb(1'b1, IRQ_MASK_OFF, 32'hf7, 33'h0, 33'h0);
        apb(1'b0, IRQ_STAT_OFF, 32'h0, 33'h0, 33'hf);
        cmp_out({3'h0, irq}, 4'h0, "irq clear");
        rd_mr(MR_MAKER, MAKER);
        apb(1'b0, 12'h100, 32'h0, {1'b1, 32'h0}, 33'h1ffffffff);
        $display("test temperature and status done");
        for (c = 0; c < 6; c++)
        begin
            mr(1'b1, MR_BURST, CFGS[c]);
            col = 11'($urandom) & 11'h7fe;
            if (CFGS[c][4])
                col = (col & 11'h7f6) | 11'h010;
            n = (CFGS[c][2:0] == 3'h4) ? 16 : (CFGS[c][2:0] == 3'h3) ? 8 : 4;
            for (i = 0; i < n; i++)
                cq.push_back({i == n - 1, CFGS[c][4] ? col + 11'(i) : CFGS[c][3] ?
                    (col & ~11'(n - 1)) | ((col ^ 11'(i)) & 11'(n - 1)) :
                    (col & ~11'(n - 1)) | ((col + 11'(i)) & 11'(n - 1))});
            apb(1'b1, BURST_OFF, {21'h0, col | 11'h001}, 33'h0, 33'h0);
            wait_idle();
            cmp_out({3'h0, cq.size() == 0}, 4'h1, "beats missing");
        end
        for (c = 0; c < 2; c++)
        begin
            apb(1'b1, IRQ_STAT_OFF, 32'hf, 33'h0, 33'h0);
            mr(1'b1, MR_BURST, RCFG[c]);
            apb(1'b1, BURST_OFF, {21'h0, RCOL[c]}, 33'h0, 33'h0);
            wait_idle();
            apb(1'b0, IRQ_STAT_OFF, 32'h0, 33'h4, 33'h4);
        end
        $display("test bursts done");
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
